// ### design/rsc_cfg.svh
/*
  Constants of the reset source control block: register offsets, field positions, reset values and timing.
  Assumes it is included by its bare name wherever these values are needed.
*/
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_CLK_MHZ 200
`define RSC_LVR_QUAL_NS 1000
`define RSC_SOFT_RST_NS 1000

`define RSC_ADDR_W 5
`define RSC_OFS_BROWNOUT_LEVEL_SELECT 5'h00
`define RSC_OFS_CTRL 5'h04
`define RSC_OFS_WATCHDOG_CONTROL_REG 5'h08
`define RSC_OFS_STAT 5'h0C
`define RSC_OFS_IRQS 5'h10
`define RSC_OFS_IRQM 5'h14

`define RSC_LVS_2V10 8'h55
`define RSC_LVS_2V55 8'h33
`define RSC_LVS_3V15 8'h99
`define RSC_LVS_3V80 8'hAA
`define RSC_BROWNOUT_LEVEL_SELECT_POR 8'h55

`define RSC_WATCHDOG_CONTROL_REG_POR 8'h53
`define RSC_WE_ENABLE 5'h0A
`define RSC_WE_DISABLE 5'h15
`define RSC_WE_LSB 3

`define RSC_CTRL_FSYS 7
`define RSC_CTRL_SUBF 3
`define RSC_CTRL_BROWNOUT_RESET_FLAG 2
`define RSC_CTRL_LRF 1
`define RSC_CTRL_WRF 0

`define RSC_STAT_TO 5
`define RSC_STAT_PDF 4

`define RSC_IRQ_W 4
`define RSC_IRQ_LVR 0
`define RSC_IRQ_LRF 1
`define RSC_IRQ_WRF 2
`define RSC_IRQ_TO 3

`endif

// ### design/rsc_delay.sv
/*
  Qualifying delay: pulses done once the run level has stood for CYCLES clock cycles.
  Assumes run comes from logic on the same clock.
*/
module rsc_delay #(
  parameter int unsigned CYCLES = 200
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic run,
  output logic done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] FULL = CW'(CYCLES);

  logic [CW-1:0] cnt_ff;
  logic done_ff;

  // The count restarts whenever run drops, so short pulses are ignored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (!run) begin
      cnt_ff <= '0;
    end else if (cnt_ff != FULL) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= run && (cnt_ff == LAST);
    end
  end

  assign done = done_ff;

endmodule

// ### design/rsc_pkg.sv
/*
  Types shared by the reset source control block.
  Assumes nothing of its surroundings.
*/
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_THR_2V10,
    RSC_THR_2V55,
    RSC_THR_3V15,
    RSC_THR_3V80
  } rsc_thr_t;

  typedef struct packed {
    logic valid;
    rsc_thr_t thr;
  } rsc_lvs_t;

  typedef struct packed {
    logic pc_clear;
    logic sp_top_load;
    logic sp_zero;
    logic int_disable;
    logic timers_off;
    logic io_as_inputs;
    logic wdt_clear;
  } rsc_init_t;

endpackage

// ### design/rsc_top.sv
/*
  Reset source control: brown-out level select, reset cause flags, watchdog reset handling,
  time-out and power-down flags, power-on initial state strobes, Avalon-MM register slave.
  Assumes a brown-out comparator pin, a watchdog time-out pulse on clk and a sleep/idle level on clk.
*/
// Notes on behaviour
// - Four select codes pick four brown-out thresholds.
// - Undefined select code resets device, reloads select.
// - That reset waits the software-reset delay.
// - Low supply must outlast qualification time.
// - Brown-out reset keeps the select register.
// - Brown-out sets flag bit 2; software clears.
// - Undefined select sets flag bit 1; software clears.
// - Control bits 6 to 4 read zero.
// - Normal watchdog time-out: full reset, sets time-out.
// - Sleep time-out clears PC, SP; sets time-out.
// - Flags follow reset type as tabulated.
// - Power-on clears watchdog, time bases; watchdog runs.
// - Power-on clears every interrupt enable.
// - Power-on switches timers off.
// - Power-on makes all I/O pins inputs.
// - Power-on loads stack pointer to top.
// - Watchdog control reset sets flag; software clears.
// - Undefined watchdog enable code resets after delay.
`include "rsc_cfg.svh"

module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned LVR_QUAL_CYC = (`RSC_LVR_QUAL_NS * `RSC_CLK_MHZ + 999) / 1000,
  parameter int unsigned SOFT_RST_CYC = (`RSC_SOFT_RST_NS * `RSC_CLK_MHZ + 999) / 1000
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave.
  input wire logic [`RSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Reset sources.
  input wire logic low_supply,
  input wire logic wdt_timeout,
  input wire logic cpu_low_power,
  input wire logic subclk_soft_reset,
  // Reset results.
  output logic full_reset,
  output rsc_init_t core_init,
  output rsc_thr_t brownout_threshold,
  output logic watchdog_run,
  output logic sysclk_in_idle_enable,
  output logic irq
);

  // Decodes the brown-out threshold select code.
  function automatic rsc_lvs_t lvs_decode(input logic [7:0] code);
    rsc_lvs_t r;
    r.valid = 1'b1;
    r.thr = RSC_THR_2V10;
    unique case (code)
      `RSC_LVS_2V10: r.thr = RSC_THR_2V10;
      `RSC_LVS_2V55: r.thr = RSC_THR_2V55;
      `RSC_LVS_3V15: r.thr = RSC_THR_3V15;
      `RSC_LVS_3V80: r.thr = RSC_THR_3V80;
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction

  // True when the watchdog enable code is one of the two defined values.
  function automatic logic we_valid(input logic [7:0] watchdog_control_reg);
    logic [4:0] we;
    we = watchdog_control_reg[7:`RSC_WE_LSB];
    return (we == `RSC_WE_ENABLE) || (we == `RSC_WE_DISABLE);
  endfunction

  logic [7:0] brownout_level_select_ff;
  logic [7:0] watchdog_control_reg_ff;
  logic sysclk_in_idle_enable_ff;
  logic subclk_ctrl_invalid_flag_ff;
  logic brownout_reset_flag_ff;
  logic brownout_select_invalid_flag_ff;
  logic watchdog_ctrl_invalid_flag_ff;
  logic watchdog_timeout_flag_ff;
  logic powerdown_flag_ff;
  logic [`RSC_IRQ_W-1:0] irq_status_ff;
  logic [`RSC_IRQ_W-1:0] irq_mask_ff;
  logic lvr_pend_ff;
  logic watchdog_control_reg_pend_ff;
  logic supply_sync1_ff;
  logic supply_sync2_ff;
  logic por_done_ff;
  logic waitreq_ff;
  logic [31:0] readdata_ff;
  logic full_reset_ff;
  rsc_init_t core_init_ff;
  rsc_thr_t threshold_ff;
  logic watchdog_run_ff;
  logic irq_ff;

  rsc_lvs_t lvs_now;
  logic lvs_bad;
  logic we_bad;
  logic lvr_done;
  logic soft_done;
  logic wdt_norm;
  logic wdt_slp;
  logic full_rst_evt;
  logic bus_wr;
  logic wr_lane0;
  logic [7:0] wdat;
  logic [`RSC_IRQ_W-1:0] irq_evt;
  logic [31:0] nxt_readdata;

  assign lvs_now = lvs_decode(brownout_level_select_ff);
  assign lvs_bad = !lvs_now.valid;
  assign we_bad = !we_valid(watchdog_control_reg_ff);
  assign wdt_norm = wdt_timeout && !cpu_low_power;
  assign wdt_slp = wdt_timeout && cpu_low_power;
  assign full_rst_evt = lvr_done || soft_done || wdt_norm;
  assign bus_wr = avs_write && !waitreq_ff;
  assign wr_lane0 = bus_wr && avs_byteenable[0];
  assign wdat = avs_writedata[7:0];

  // Low supply arrives from the comparator pin, so it is synchronised first.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_sync1_ff <= 1'b0;
      supply_sync2_ff <= 1'b0;
    end else begin
      supply_sync1_ff <= low_supply;
      supply_sync2_ff <= supply_sync1_ff;
    end
  end

  // Brown-out detection is off while the core is powered down.
  rsc_delay #(
    .CYCLES(LVR_QUAL_CYC)
  ) u_lvr_qual (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(supply_sync2_ff && !cpu_low_power),
    .done(lvr_done)
  );

  // Undefined codes are latched so that the reset still follows if software repairs them.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvr_pend_ff <= 1'b0;
      watchdog_control_reg_pend_ff <= 1'b0;
    end else if (soft_done) begin
      lvr_pend_ff <= 1'b0;
      watchdog_control_reg_pend_ff <= 1'b0;
    end else begin
      lvr_pend_ff <= lvr_pend_ff || lvs_bad;
      watchdog_control_reg_pend_ff <= watchdog_control_reg_pend_ff || we_bad;
    end
  end

  rsc_delay #(
    .CYCLES(SOFT_RST_CYC)
  ) u_soft_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(lvr_pend_ff || watchdog_control_reg_pend_ff),
    .done(soft_done)
  );

  // Brown-out select: kept over a brown-out reset, reloaded by the other full resets.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brownout_level_select_ff <= `RSC_BROWNOUT_LEVEL_SELECT_POR;
    end else if (soft_done || wdt_norm) begin
      brownout_level_select_ff <= `RSC_BROWNOUT_LEVEL_SELECT_POR;
    end else if (lvr_done) begin
      brownout_level_select_ff <= brownout_level_select_ff;
    end else if (wr_lane0 && avs_address == `RSC_OFS_BROWNOUT_LEVEL_SELECT) begin
      brownout_level_select_ff <= wdat;
    end
  end

  // Watchdog control returns to its power-on value on every full reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_control_reg_ff <= `RSC_WATCHDOG_CONTROL_REG_POR;
    end else if (full_rst_evt) begin
      watchdog_control_reg_ff <= `RSC_WATCHDOG_CONTROL_REG_POR;
    end else if (wr_lane0 && avs_address == `RSC_OFS_WATCHDOG_CONTROL_REG) begin
      watchdog_control_reg_ff <= wdat;
    end
  end

  // Idle clock enable is cleared by every reset, the sleep time-out included.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysclk_in_idle_enable_ff <= 1'b0;
    end else if (full_rst_evt || wdt_slp) begin
      sysclk_in_idle_enable_ff <= 1'b0;
    end else if (wr_lane0 && avs_address == `RSC_OFS_CTRL) begin
      sysclk_in_idle_enable_ff <= wdat[`RSC_CTRL_FSYS];
    end
  end

  // Cause flags: hardware sets, software writes zero to clear, set wins over clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brownout_reset_flag_ff <= 1'b0;
      brownout_select_invalid_flag_ff <= 1'b0;
      watchdog_ctrl_invalid_flag_ff <= 1'b0;
      subclk_ctrl_invalid_flag_ff <= 1'b0;
    end else begin
      if (lvr_done) begin
        brownout_reset_flag_ff <= 1'b1;
      end else if (wr_lane0 && avs_address == `RSC_OFS_CTRL && !wdat[`RSC_CTRL_BROWNOUT_RESET_FLAG]) begin
        brownout_reset_flag_ff <= 1'b0;
      end
      if (lvs_bad) begin
        brownout_select_invalid_flag_ff <= 1'b1;
      end else if (wr_lane0 && avs_address == `RSC_OFS_CTRL && !wdat[`RSC_CTRL_LRF]) begin
        brownout_select_invalid_flag_ff <= 1'b0;
      end
      if (soft_done && watchdog_control_reg_pend_ff) begin
        watchdog_ctrl_invalid_flag_ff <= 1'b1;
      end else if (wr_lane0 && avs_address == `RSC_OFS_CTRL && !wdat[`RSC_CTRL_WRF]) begin
        watchdog_ctrl_invalid_flag_ff <= 1'b0;
      end
      if (subclk_soft_reset) begin
        subclk_ctrl_invalid_flag_ff <= 1'b1;
      end else if (wr_lane0 && avs_address == `RSC_OFS_CTRL && !wdat[`RSC_CTRL_SUBF]) begin
        subclk_ctrl_invalid_flag_ff <= 1'b0;
      end
    end
  end

  // Time-out and power-down flags: cleared by power-on, untouched by brown-out and soft resets.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_timeout_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b0;
    end else begin
      if (wdt_timeout) begin
        watchdog_timeout_flag_ff <= 1'b1;
      end
      if (wdt_slp) begin
        powerdown_flag_ff <= 1'b1;
      end
    end
  end

  // Interrupt status and mask; the mask starts cleared so nothing is signalled until enabled.
  assign irq_evt = {wdt_timeout, soft_done && watchdog_control_reg_pend_ff, lvs_bad && !lvr_pend_ff, lvr_done};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_ff <= '0;
    end else if (wr_lane0 && avs_address == `RSC_OFS_IRQS) begin
      irq_status_ff <= irq_evt | (irq_status_ff & ~wdat[`RSC_IRQ_W-1:0]);
    end else begin
      irq_status_ff <= irq_status_ff | irq_evt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_ff <= '0;
    end else if (wr_lane0 && avs_address == `RSC_OFS_IRQM) begin
      irq_mask_ff <= wdat[`RSC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // Full reset pulse and core initial-state strobes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_done_ff <= 1'b0;
    end else begin
      por_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_reset_ff <= 1'b0;
      core_init_ff <= '0;
    end else begin
      full_reset_ff <= full_rst_evt;
      core_init_ff <= '0;
      if (!por_done_ff || full_rst_evt) begin
        core_init_ff.pc_clear <= 1'b1;
        core_init_ff.sp_top_load <= 1'b1;
        core_init_ff.int_disable <= 1'b1;
        core_init_ff.timers_off <= 1'b1;
        core_init_ff.io_as_inputs <= 1'b1;
        core_init_ff.wdt_clear <= 1'b1;
      end else if (wdt_slp) begin
        core_init_ff.pc_clear <= 1'b1;
        core_init_ff.sp_zero <= 1'b1;
      end
    end
  end

  // Threshold and watchdog run outputs; the watchdog runs from power-on with its enable code.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      threshold_ff <= RSC_THR_2V10;
      watchdog_run_ff <= 1'b0;
    end else begin
      threshold_ff <= lvs_now.thr;
      watchdog_run_ff <= (watchdog_control_reg_ff[7:`RSC_WE_LSB] == `RSC_WE_ENABLE);
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    nxt_readdata = '0;
    unique case (avs_address)
      `RSC_OFS_BROWNOUT_LEVEL_SELECT: nxt_readdata[7:0] = brownout_level_select_ff;
      `RSC_OFS_CTRL: nxt_readdata[7:0] = {sysclk_in_idle_enable_ff, 3'h0, subclk_ctrl_invalid_flag_ff,
                                          brownout_reset_flag_ff, brownout_select_invalid_flag_ff,
                                          watchdog_ctrl_invalid_flag_ff};
      `RSC_OFS_WATCHDOG_CONTROL_REG: nxt_readdata[7:0] = watchdog_control_reg_ff;
      `RSC_OFS_STAT: begin
        nxt_readdata[`RSC_STAT_TO] = watchdog_timeout_flag_ff;
        nxt_readdata[`RSC_STAT_PDF] = powerdown_flag_ff;
      end
      `RSC_OFS_IRQS: nxt_readdata[`RSC_IRQ_W-1:0] = irq_status_ff;
      `RSC_OFS_IRQM: nxt_readdata[`RSC_IRQ_W-1:0] = irq_mask_ff;
      default: nxt_readdata = '0;
    endcase
  end

  // Waitrequest drops for one cycle, one cycle after a request appears.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitreq_ff <= 1'b1;
      readdata_ff <= '0;
    end else if (!waitreq_ff) begin
      waitreq_ff <= 1'b1;
    end else if (avs_read || avs_write) begin
      waitreq_ff <= 1'b0;
      readdata_ff <= avs_read ? nxt_readdata : '0;
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign full_reset = full_reset_ff;
  assign core_init = core_init_ff;
  assign brownout_threshold = threshold_ff;
  assign watchdog_run = watchdog_run_ff;
  assign sysclk_in_idle_enable = sysclk_in_idle_enable_ff;
  assign irq = irq_ff;

endmodule

// ### test/rsc_top_properties.sv
/*
  Checker of the reset source control block, seeing only the ports of rsc_top.
  Assumes the bind at the foot of this file and one clock domain with sys_rst.
*/
`include "rsc_cfg.svh"

module rsc_chk
  import rsc_pkg::*;
#(
  parameter int unsigned LVR_QUAL_CYC = 4,
  parameter int unsigned SOFT_RST_CYC = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus.
  input wire logic [`RSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Sources and results.
  input wire logic low_supply,
  input wire logic wdt_timeout,
  input wire logic cpu_low_power,
  input wire logic full_reset,
  input wire rsc_init_t core_init,
  input wire rsc_thr_t brownout_threshold,
  input wire logic watchdog_run
);
  localparam int SOFT_LO = SOFT_RST_CYC;
  localparam logic [7:0] LVR_N = 8'(LVR_QUAL_CYC + 6);
  logic [7:0] lvr_cnt_ff;
  logic seen_ff;

  function automatic rsc_thr_t thr_of(input logic [7:0] c);
    case (c)
      `RSC_LVS_2V55: return RSC_THR_2V55;
      `RSC_LVS_3V15: return RSC_THR_3V15;
      `RSC_LVS_3V80: return RSC_THR_3V80;
      default: return RSC_THR_2V10;
    endcase
  endfunction

  // Counts consecutive cycles of a qualifying low supply.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) lvr_cnt_ff <= 8'h00;
    else if (!low_supply || cpu_low_power) lvr_cnt_ff <= 8'h00;
    else if (lvr_cnt_ff != 8'hFF) lvr_cnt_ff <= lvr_cnt_ff + 8'h01;
  end

  // Notes a full reset seen during the current low supply run.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) seen_ff <= 1'b0;
    else if (lvr_cnt_ff == 8'h00) seen_ff <= 1'b0;
    else if (full_reset) seen_ff <= 1'b1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_ctrl_unused_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == `RSC_OFS_CTRL |-> avs_readdata[6:4] == 3'h0)
    else $error("control read shows unused bits set");
  chk_thr_decode_map: assert property (
    avs_read && !avs_waitrequest && avs_address == `RSC_OFS_BROWNOUT_LEVEL_SELECT &&
    avs_readdata[7:0] inside {8'h55, 8'h33, 8'h99, 8'hAA} |-> brownout_threshold == thr_of(avs_readdata[7:0]))
    else $error("threshold does not follow select code");
  chk_lvr_qualify_run: assert property (lvr_cnt_ff == LVR_N |-> seen_ff)
    else $error("long low supply gave no reset");
  chk_full_init_set: assert property (
    full_reset |-> core_init.int_disable && core_init.timers_off && core_init.io_as_inputs &&
    core_init.sp_top_load && !core_init.sp_zero)
    else $error("full reset without initial state strobes");
  chk_por_wdt_start: assert property (
    $fell(sys_rst) |=> core_init.wdt_clear && core_init.pc_clear && watchdog_run)
    else $error("power-on did not clear and start watchdog");
  chk_wdt_normal_reset: assert property (wdt_timeout && !cpu_low_power |-> ##[1:2] full_reset)
    else $error("normal time-out gave no full reset");
  chk_wdt_sleep_only: assert property (
    wdt_timeout && cpu_low_power |-> ##[1:2] (core_init.pc_clear && core_init.sp_zero && !full_reset))
    else $error("sleep time-out wrong reset");
  chk_bad_code_delay: assert property (
    avs_write && !avs_waitrequest && avs_address == `RSC_OFS_BROWNOUT_LEVEL_SELECT &&
    !(avs_writedata[7:0] inside {8'h55, 8'h33, 8'h99, 8'hAA}) |->
    (!full_reset throughout (1'b1 ##SOFT_LO 1'b1)) ##[1:4] full_reset)
    else $error("invalid select reset timing wrong");
endmodule

bind rsc_top rsc_chk #(.LVR_QUAL_CYC(LVR_QUAL_CYC), .SOFT_RST_CYC(SOFT_RST_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .low_supply(low_supply), .wdt_timeout(wdt_timeout), .cpu_low_power(cpu_low_power),
  .full_reset(full_reset), .core_init(core_init), .brownout_threshold(brownout_threshold),
  .watchdog_run(watchdog_run));

// ### test/test_rsc_top.sv
/*
  Self-checking testbench of the reset source control block.
  Assumes rsc_top with short counts and the checker bound to it.
*/
`include "rsc_cfg.svh"

module test_rsc_top
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`RSC_ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, low_supply, wdt_timeout, cpu_low_power;
  logic subclk_soft_reset, full_reset, watchdog_run, sysclk_in_idle_enable, irq;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  rsc_init_t core_init;
  rsc_thr_t brownout_threshold;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int nrst = 0;
  int n0;
  logic [31:0] exp_q[$];
  logic [7:0] codes[4] = '{8'h55, 8'h33, 8'h99, 8'hAA};

  always #2.5 clk = ~clk;

  rsc_top #(.LVR_QUAL_CYC(4), .SOFT_RST_CYC(4)) dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .low_supply(low_supply), .wdt_timeout(wdt_timeout),
    .cpu_low_power(cpu_low_power), .subclk_soft_reset(subclk_soft_reset), .full_reset(full_reset),
    .core_init(core_init), .brownout_threshold(brownout_threshold), .watchdog_run(watchdog_run),
    .sysclk_in_idle_enable(sysclk_in_idle_enable), .irq(irq));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'($urandom), d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic tick(input logic slp, input int lo);
    @(posedge clk);
    cpu_low_power <= slp;
    wdt_timeout <= lo == 0;
    low_supply <= lo > 0;
    repeat (lo > 0 ? lo : 1) @(posedge clk);
    {cpu_low_power, wdt_timeout, low_supply} <= 3'h0;
    repeat (12) @(posedge clk);
  endtask

  // Takes each read result off the queue of expectations.
  always @(posedge clk) begin
    cycles++;
    if (full_reset === 1'b1) nrst++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
    if (cycles == 3000) begin
      mismatches++;
      close_out;
    end
  end

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, subclk_soft_reset} = '0;
    {low_supply, wdt_timeout, cpu_low_power} = 3'h0;
    avs_byteenable = 4'hF;
    void'($urandom(59));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h55);
    rd(`RSC_OFS_STAT, 8'h00);
    rd(`RSC_OFS_WATCHDOG_CONTROL_REG, 8'h53);
    rd(5'h18, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`RSC_OFS_BROWNOUT_LEVEL_SELECT, codes[(i + $urandom) % 4]);
      wr(`RSC_OFS_BROWNOUT_LEVEL_SELECT, codes[i]);
      rd(`RSC_OFS_BROWNOUT_LEVEL_SELECT, codes[i]);
      check({30'h0, brownout_threshold}, 32'(i));
    end
    @(posedge clk);
    subclk_soft_reset <= 1'b1;
    @(posedge clk);
    subclk_soft_reset <= 1'b0;
    wr(`RSC_OFS_CTRL, 8'hFF);
    rd(`RSC_OFS_CTRL, 8'h88);
    check(sysclk_in_idle_enable, 1'b1);
    wr(`RSC_OFS_CTRL, 8'h80);
    rd(`RSC_OFS_CTRL, 8'h80);
    wr(`RSC_OFS_IRQM, 8'h0F);
    wr(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h33);
    n0 = nrst;
    tick(1'b0, 0);
    check(nrst - n0, 1);
    check(sysclk_in_idle_enable, 1'b0);
    rd(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h55);
    rd(`RSC_OFS_STAT, 8'h20);
    wr(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h99);
    tick(1'b1, 0);
    check(nrst - n0, 1);
    rd(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h99);
    rd(`RSC_OFS_STAT, 8'h30);
    tick(1'b0, 3);
    check(nrst - n0, 1);
    tick(1'b0, 12);
    check(nrst > n0 + 1, 1);
    rd(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h99);
    rd(`RSC_OFS_STAT, 8'h30);
    rd(`RSC_OFS_CTRL, 8'h04);
    rd(`RSC_OFS_IRQS, 8'h09);
    check(irq, 1);
    wr(`RSC_OFS_IRQM, 8'h00);
    repeat (2) @(posedge clk);
    check(irq, 0);
    wr(`RSC_OFS_IRQM, 8'h0F);
    wr(`RSC_OFS_IRQS, 8'h0F);
    repeat (2) @(posedge clk);
    check(irq, 0);
    wr(`RSC_OFS_CTRL, 8'h04);
    rd(`RSC_OFS_CTRL, 8'h04);
    wr(`RSC_OFS_CTRL, 8'h00);
    rd(`RSC_OFS_CTRL, 8'h00);
    n0 = nrst;
    wr(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h00);
    repeat (12) @(posedge clk);
    check(nrst - n0, 1);
    rd(`RSC_OFS_BROWNOUT_LEVEL_SELECT, 8'h55);
    rd(`RSC_OFS_CTRL, 8'h02);
    wr(`RSC_OFS_CTRL, 8'h00);
    rd(`RSC_OFS_CTRL, 8'h00);
    wr(`RSC_OFS_WATCHDOG_CONTROL_REG, 8'hA8);
    repeat (2) @(posedge clk);
    check(watchdog_run, 0);
    n0 = nrst;
    wr(`RSC_OFS_WATCHDOG_CONTROL_REG, 8'h00);
    repeat (12) @(posedge clk);
    check(nrst - n0, 1);
    check(watchdog_run, 1);
    rd(`RSC_OFS_WATCHDOG_CONTROL_REG, 8'h53);
    rd(`RSC_OFS_CTRL, 8'h01);
    wr(`RSC_OFS_CTRL, 8'h00);
    rd(`RSC_OFS_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    close_out;
  end
endmodule
